//--- design/tiu_defines.svh
// named constants of the timer and interrupt unit
// assumes: included by bare name from the design modules
`ifndef TIU_DEFINES_SVH
`define TIU_DEFINES_SVH

// register indices on the plain port
`define TIU_ADR_FLAGS_A     6'h00
`define TIU_ADR_FLAGS_B     6'h01
`define TIU_ADR_ENABLES_A   6'h02
`define TIU_ADR_ENABLES_B   6'h03
`define TIU_ADR_STATUS      6'h04
`define TIU_ADR_GLOBAL_TIMER_CONTROL    6'h05
`define TIU_ADR_WATERMARK   6'h06
`define TIU_ADR_WAKE_CTRL   6'h07
`define TIU_ADR_TIMER_BASE  6'h10
`define TIU_TIMER_STRIDE    6'h08
// per-timer register sub-offsets
`define TIU_SUB_CTRL        3'h0
`define TIU_SUB_RLD_HI      3'h1
`define TIU_SUB_RLD_LO      3'h2
`define TIU_SUB_CNT_HI      3'h3
`define TIU_SUB_CNT_LO      3'h4

// flag and enable register field positions
`define TIU_SET_BIT         7
`define TIU_A_TX            0
`define TIU_A_RX            1
`define TIU_A_IDLE          2
`define TIU_A_HIGH          3
`define TIU_A_LOW           4
`define TIU_A_ERR           5
`define TIU_A_CARD          6
`define TIU_B_TIMER0        0
`define TIU_B_SOF           4
`define TIU_B_GLOBAL        6
// status bit positions: summary request and standby
`define TIU_STAT_IRQ        0
`define TIU_STAT_STANDBY    1

// timer control fields
`define TIU_TC_CLK_LSB      0
`define TIU_TC_AUTO         2
`define TIU_TC_START        3
`define TIU_TC_STOP_EN      4
`define TIU_WK_AUTO         0
`define TIU_WK_RUN          1
`define TIU_WK_AUTO_RST     2

// reset values, count constants and FIFO size
`define TIU_RST_BYTE        8'h00
`define TIU_RST_COUNT       16'h0000
`define TIU_ZERO_COUNT      16'h0000
`define TIU_ONE_COUNT       16'h0001
`define TIU_RST_WATERMARK   9'h008
`define TIU_FIFO_SIZE       10'h200

// clock rates and divider counts
`define TIU_SYS_KHZ         250000
`define TIU_FAST_KHZ        13560
`define TIU_SLOW_KHZ        212
`define TIU_FAST_DIV        (`TIU_SYS_KHZ / `TIU_FAST_KHZ)
`define TIU_SLOW_DIV        (`TIU_SYS_KHZ / `TIU_SLOW_KHZ)
`define TIU_DIV_W           12

`endif

//--- design/tiu_pkg.sv
// types of the timer and interrupt unit
// assumes: tiu_defines.svh holds the register and count numbers; enum encodings stand here
package tiu_pkg;

  // timer clock selection
  typedef enum logic [1:0] {
    tiu_clk_fast_type_e = 2'h0,
    tiu_clk_slow_type_e = 2'h1,
    tiu_clk_wake_type_e = 2'h2,
    tiu_clk_none_type_e = 2'h3
  } tiu_clksel_type;

  // wake-up power state, one-hot
  typedef enum logic [2:0] {
    tiu_pw_awake   = 3'h1,
    tiu_pw_standby = 3'h2,
    tiu_pw_check   = 3'h4
  } tiu_power_type;

endpackage

//--- design/tiu_tick_gen.sv
// divider making one-cycle tick enables for the two timer clocks
// assumes: single clk, asynchronous active-high rst
`timescale 1ns/1ns
`include "tiu_defines.svh"

module tiu_tick_gen (
  input  wire logic clk,
  input  wire logic rst,
  output logic      fast_tick,
  output logic      slow_tick
);

  logic [`TIU_DIV_W-1:0] fast_cnt_r;
  logic [`TIU_DIV_W-1:0] slow_cnt_r;

  localparam logic [`TIU_DIV_W-1:0] FAST_LAST =
    `TIU_DIV_W'(`TIU_FAST_DIV - 1);
  localparam logic [`TIU_DIV_W-1:0] SLOW_LAST =
    `TIU_DIV_W'(`TIU_SLOW_DIV - 1);

  // free-running dividers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fast_cnt_r <= '0;
      slow_cnt_r <= '0;
    end else begin
      fast_cnt_r <= (fast_cnt_r == FAST_LAST) ? '0 : fast_cnt_r + 1'b1;
      slow_cnt_r <= (slow_cnt_r == SLOW_LAST) ? '0 : slow_cnt_r + 1'b1;
    end
  end

  assign fast_tick = (fast_cnt_r == FAST_LAST);
  assign slow_tick = (slow_cnt_r == SLOW_LAST);

endmodule

//--- design/tiu_timer.sv
// one 16-bit down-counting general timer
// assumes: ticks are one-cycle enables on clk; control from the top
`timescale 1ns/1ns
`include "tiu_defines.svh"

module tiu_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        stop_event,
  input  wire logic        stop_en,
  input  wire logic        auto_reload,
  input  wire logic [15:0] reload,
  input  wire logic        cnt_wr,
  input  wire logic [15:0] cnt_wdata,
  output logic [15:0]      count_r,
  output logic             running_r,
  output logic             underflow
);

  // underflow: tick while running at zero
  assign underflow = running_r && tick && (count_r == `TIU_ZERO_COUNT);

  // run state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_r <= 1'b0;
    end else if (start) begin
      running_r <= 1'b1;
    end else if (stop || (stop_en && stop_event && !underflow)) begin
      running_r <= 1'b0;
    end else if (underflow && !auto_reload) begin
      running_r <= 1'b0;
    end
  end

  // counter value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= `TIU_RST_COUNT;
    end else if (cnt_wr) begin
      count_r <= cnt_wdata;
    end else if (start) begin
      count_r <= reload;
    end else if (underflow && auto_reload) begin
      count_r <= reload;
    end else if (running_r && tick && !underflow
                 && !(stop_en && stop_event)) begin
      count_r <= count_r - `TIU_ONE_COUNT;
    end
  end

  tick_dec_a: assert property (@(posedge clk) disable iff (rst)
    running_r && tick && !cnt_wr && !start && !stop && !stop_event
    && count_r != `TIU_ZERO_COUNT |=> count_r == $past(count_r) - 16'h0001)
    else $error("timer did not decrement on tick");

  one_shot_a: assert property (@(posedge clk) disable iff (rst)
    underflow && !auto_reload && !start |=> !running_r)
    else $error("one-shot timer kept running");

endmodule

//--- design/tiu_top.sv
// timer and interrupt unit: four general timers, wake timer, flags
// assumes: single 250 MHz clk; register port on same clock;
// event inputs are same-clock pulses except card_detect and lfo_tick pins (synced)
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "tiu_defines.svh"

// What this block does
// - two 8-bit flag and enable registers; bit 7 picks set or clear.
// - enabled events set summary status bit and the request pin.
// - each general timer underflow sets its own flag in flags b.
// - transmit data-to-end-of-frame change sets the transmit-done flag.
// - end of received data sets the receive-done flag.
// - command finishing back to idle sets the idle flag.
// - one watermark gives both top and bottom FIFO thresholds.
// - high alert at top level (with extension bit) sets FIFO-high flag.
// - low alert at bottom level sets FIFO-low flag.
// - any receive error bit set raises the error flag.
// - card found in low-power detection mode sets card-detect flag.
// - start-of-frame or subcarrier during reception sets start flag.
// - any enabled source flag set raises the global flag.
// - per-timer clock select: 13.56 MHz, 212 kHz or wake underflow.
// - 16-bit counter and reload, each as high and low bytes.
// - global control starts, stops and reports each timer running.
// - running timer decrements once per selected tick.
// - at zero, next tick raises the timer interrupt.
// - underflow stops at zero or reloads, per auto-restart setting.
// - stop event before underflow stops timer with no interrupt.
// - wake timer wakes from standby; auto mode returns if no card.
module tiu_top (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic [7:0]      rdata,
  input  wire logic       tx_data_to_eof,
  input  wire logic       rx_end,
  input  wire logic       cmd_to_idle,
  input  wire logic [9:0] fifo_level,
  input  wire logic [7:0] rx_error,
  input  wire logic       rx_sof_seen,
  input  wire logic       card_detect,
  input  wire logic       lfo_tick,
  input  wire logic [3:0] timer_stop_event,
  output logic            irq,
  output logic            standby
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]  flags_a_r, flags_b_r, en_a_r, en_b_r;
  logic [7:0]  flags_a_nxt, flags_b_nxt;
  logic [8:0]  watermark_r;
  logic [2:0]  wake_ctrl_r;
  logic [7:0]  tctrl_r [4];
  logic [15:0] reload_r [4];
  logic [15:0] count [4];
  logic [3:0]  running, underflow, tick, start, stop, cnt_wr;
  logic [15:0] wake_cnt_r;
  logic [15:0] wake_reload_r;
  logic        wake_uf;
  logic        fast_tick, slow_tick;
  logic        card_s1_r, card_s2_r, card_d_r;
  logic        lfo_s1_r, lfo_s2_r, lfo_d_r;
  logic        card_rise, lfo_rise;
  logic        high_alert, low_alert, high_d_r, low_d_r;
  logic        irq_any;
  tiu_pkg::tiu_power_type pw_r;

  // decode of a per-timer address; returns whether it hits that timer and sub-offset
  function automatic logic timer_hit(input logic [5:0] a,
                                     input int unsigned idx,
                                     input logic [2:0] sub);
    logic [5:0] base;
    base = 6'(`TIU_ADR_TIMER_BASE + 6'(idx) * `TIU_TIMER_STRIDE);
    return a == base + {3'h0, sub};
  endfunction

  // set or clear by bit 7 of the written byte
  function automatic logic [7:0] set_clear(input logic [7:0] old,
                                           input logic [7:0] wd);
    logic [7:0] m;
    m = {1'b0, wd[6:0]};
    return wd[`TIU_SET_BIT] ? (old | m) : (old & ~m);
  endfunction

  // ****************************************************************
  // input synchronisers and dividers
  // ****************************************************************
  // two-flop sync of pins from other domains, then edge detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_s1_r <= 1'b0;
      card_s2_r <= 1'b0;
      card_d_r  <= 1'b0;
      lfo_s1_r  <= 1'b0;
      lfo_s2_r  <= 1'b0;
      lfo_d_r   <= 1'b0;
    end else begin
      card_s1_r <= card_detect;
      card_s2_r <= card_s1_r;
      card_d_r  <= card_s2_r;
      lfo_s1_r  <= lfo_tick;
      lfo_s2_r  <= lfo_s1_r;
      lfo_d_r   <= lfo_s2_r;
    end
  end
  assign card_rise = card_s2_r && !card_d_r;
  assign lfo_rise  = lfo_s2_r && !lfo_d_r;

  tiu_tick_gen u_ticks (
    .clk       (clk),
    .rst       (rst),
    .fast_tick (fast_tick),
    .slow_tick (slow_tick)
  );

  // ****************************************************************
  // general timers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tmr
      tiu_pkg::tiu_clksel_type sel;
      assign sel = tiu_pkg::tiu_clksel_type'(
        tctrl_r[gi][`TIU_TC_CLK_LSB +: 2]);
      // clock source select
      always_comb begin
        case (sel)
          tiu_pkg::tiu_clk_fast_type_e: tick[gi] = fast_tick;
          tiu_pkg::tiu_clk_slow_type_e: tick[gi] = slow_tick;
          tiu_pkg::tiu_clk_wake_type_e: tick[gi] = wake_uf;
          default:                      tick[gi] = 1'b0;
        endcase
      end
      // start from global control or per-timer start bit
      assign start[gi] = wr_stb && (
        (addr == `TIU_ADR_GLOBAL_TIMER_CONTROL && wdata[gi + 4] && wdata[gi])
        || (timer_hit(addr, gi, `TIU_SUB_CTRL)
            && wdata[`TIU_TC_START]));
      assign stop[gi] = wr_stb && addr == `TIU_ADR_GLOBAL_TIMER_CONTROL
                        && wdata[gi + 4] && !wdata[gi];
      assign cnt_wr[gi] = wr_stb && (timer_hit(addr, gi, `TIU_SUB_CNT_HI)
                          || timer_hit(addr, gi, `TIU_SUB_CNT_LO));

      tiu_timer u_tmr (
        .clk         (clk),
        .rst         (rst),
        .tick        (tick[gi]),
        .start       (start[gi]),
        .stop        (stop[gi]),
        .stop_event  (timer_stop_event[gi]),
        .stop_en     (tctrl_r[gi][`TIU_TC_STOP_EN]),
        .auto_reload (tctrl_r[gi][`TIU_TC_AUTO]),
        .reload      (reload_r[gi]),
        .cnt_wr      (cnt_wr[gi]),
        .cnt_wdata   (timer_hit(addr, gi, `TIU_SUB_CNT_HI)
                      ? {wdata, count[gi][7:0]}
                      : {count[gi][15:8], wdata}),
        .count_r     (count[gi]),
        .running_r   (running[gi]),
        .underflow   (underflow[gi])
      );

      // timer control and reload bytes
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          tctrl_r[gi]  <= `TIU_RST_BYTE;
          reload_r[gi] <= `TIU_RST_COUNT;
        end else if (wr_stb) begin
          if (timer_hit(addr, gi, `TIU_SUB_CTRL)) begin
            tctrl_r[gi] <= wdata & ~(8'h01 << `TIU_TC_START);
          end
          if (timer_hit(addr, gi, `TIU_SUB_RLD_HI)) begin
            reload_r[gi][15:8] <= wdata;
          end
          if (timer_hit(addr, gi, `TIU_SUB_RLD_LO)) begin
            reload_r[gi][7:0] <= wdata;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // wake timer and power state
  // ****************************************************************
  assign wake_uf = wake_ctrl_r[`TIU_WK_RUN] && lfo_rise
                   && (wake_cnt_r == `TIU_ZERO_COUNT);

  // wake counter on the low-frequency oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_cnt_r <= `TIU_RST_COUNT;
    end else if (wake_uf) begin
      wake_cnt_r <= wake_reload_r;
    end else if (wake_ctrl_r[`TIU_WK_RUN] && lfo_rise) begin
      wake_cnt_r <= wake_cnt_r - `TIU_ONE_COUNT;
    end
  end

  // power state: standby, wake check, awake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_r <= tiu_pkg::tiu_pw_awake;
    end else begin
      case (pw_r)
        tiu_pkg::tiu_pw_awake:
          if (wr_stb && addr == `TIU_ADR_STATUS
              && wdata[`TIU_STAT_STANDBY]) begin
            pw_r <= tiu_pkg::tiu_pw_standby;
          end
        tiu_pkg::tiu_pw_standby:
          if (wake_uf) begin
            pw_r <= tiu_pkg::tiu_pw_check;
          end
        tiu_pkg::tiu_pw_check:
          if (card_rise || !wake_ctrl_r[`TIU_WK_AUTO]) begin
            pw_r <= tiu_pkg::tiu_pw_awake;
          end else if (wake_uf) begin
            pw_r <= tiu_pkg::tiu_pw_standby;
          end
        default: pw_r <= tiu_pkg::tiu_pw_awake;
      endcase
    end
  end
  assign standby = (pw_r == tiu_pkg::tiu_pw_standby);

  // ****************************************************************
  // interrupt sources
  // ****************************************************************
  // one watermark: top = size - level, bottom = level
  assign high_alert = {1'b0, fifo_level} >=
                      11'(`TIU_FIFO_SIZE) - {2'h0, watermark_r};
  assign low_alert  = {1'b0, fifo_level} <=
                      {2'h0, watermark_r};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_d_r <= 1'b0;
      low_d_r  <= 1'b0;
    end else begin
      high_d_r <= high_alert;
      low_d_r  <= low_alert;
    end
  end

  // next flag values: host write first, hardware sets on top except timer sets under a host clear
  always_comb begin
    flags_a_nxt = flags_a_r;
    flags_b_nxt = flags_b_r;
    if (wr_stb && addr == `TIU_ADR_FLAGS_A) begin
      flags_a_nxt = set_clear(flags_a_r, wdata);
    end
    if (wr_stb && addr == `TIU_ADR_FLAGS_B) begin
      flags_b_nxt = set_clear(flags_b_r, wdata);
    end
    if (tx_data_to_eof) flags_a_nxt[`TIU_A_TX] = 1'b1;
    if (rx_end)         flags_a_nxt[`TIU_A_RX] = 1'b1;
    if (cmd_to_idle)    flags_a_nxt[`TIU_A_IDLE] = 1'b1;
    if (high_alert && !high_d_r) flags_a_nxt[`TIU_A_HIGH] = 1'b1;
    if (low_alert && !low_d_r)   flags_a_nxt[`TIU_A_LOW] = 1'b1;
    if (|rx_error)      flags_a_nxt[`TIU_A_ERR] = 1'b1;
    if (card_rise && pw_r != tiu_pkg::tiu_pw_awake) begin
      flags_a_nxt[`TIU_A_CARD] = 1'b1;
    end
    if (rx_sof_seen)    flags_b_nxt[`TIU_B_SOF] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      // a host clear in this cycle beats the timer set
      if (underflow[i] && !(wr_stb && addr == `TIU_ADR_FLAGS_B
          && !wdata[`TIU_SET_BIT] && wdata[i])) begin
        flags_b_nxt[`TIU_B_TIMER0 + i] = 1'b1;
      end
    end
    // current pairs too, so a flag cleared in this cycle still raises it
    flags_b_nxt[`TIU_B_GLOBAL] = flags_b_nxt[`TIU_B_GLOBAL]
      | (|(flags_a_nxt[6:0] & en_a_r[6:0]))
      | (|(flags_b_nxt[5:0] & en_b_r[5:0]))
      | (|(flags_a_r[6:0] & en_a_r[6:0]))
      | (|(flags_b_r[5:0] & en_b_r[5:0]));
    flags_a_nxt[`TIU_SET_BIT] = 1'b0;
    flags_b_nxt[`TIU_SET_BIT] = 1'b0;
  end

  // flag and enable registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_a_r <= `TIU_RST_BYTE;
      flags_b_r <= `TIU_RST_BYTE;
      en_a_r    <= `TIU_RST_BYTE;
      en_b_r    <= `TIU_RST_BYTE;
    end else begin
      flags_a_r <= flags_a_nxt;
      flags_b_r <= flags_b_nxt;
      if (wr_stb && addr == `TIU_ADR_ENABLES_A) begin
        en_a_r <= set_clear(en_a_r, wdata);
      end
      if (wr_stb && addr == `TIU_ADR_ENABLES_B) begin
        en_b_r <= set_clear(en_b_r, wdata);
      end
    end
  end

  // watermark and wake configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watermark_r   <= `TIU_RST_WATERMARK;
      wake_ctrl_r   <= '0;
      wake_reload_r <= `TIU_RST_COUNT;
    end else if (wr_stb) begin
      if (addr == `TIU_ADR_WATERMARK) watermark_r[7:0] <= wdata;
      if (addr == `TIU_ADR_WAKE_CTRL) begin
        wake_ctrl_r      <= wdata[2:0];
        watermark_r[8]   <= wdata[7]; // extension bit
      end
      if (addr == `TIU_ADR_WAKE_CTRL + 6'h01) wake_reload_r[15:8] <= wdata;
      if (addr == `TIU_ADR_WAKE_CTRL + 6'h02) wake_reload_r[7:0]  <= wdata;
    end
  end

  // request: any enabled flag, held until cleared
  assign irq_any = |(flags_a_r[6:0] & en_a_r[6:0])
                   | |(flags_b_r[6:0] & en_b_r[6:0]);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_any;
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `TIU_RST_BYTE;
    end else if (rd_stb) begin
      rdata <= `TIU_RST_BYTE;
      case (addr)
        `TIU_ADR_FLAGS_A:   rdata <= flags_a_r;
        `TIU_ADR_FLAGS_B:   rdata <= flags_b_r;
        `TIU_ADR_ENABLES_A: rdata <= en_a_r;
        `TIU_ADR_ENABLES_B: rdata <= en_b_r;
        `TIU_ADR_STATUS:    rdata <= {6'h00, standby, irq_any};
        `TIU_ADR_GLOBAL_TIMER_CONTROL:  rdata <= {4'h0, running};
        `TIU_ADR_WATERMARK: rdata <= watermark_r[7:0];
        `TIU_ADR_WAKE_CTRL: rdata <= {watermark_r[8], 4'h0, wake_ctrl_r};
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (timer_hit(addr, i, `TIU_SUB_CTRL))   rdata <= tctrl_r[i];
            if (timer_hit(addr, i, `TIU_SUB_RLD_HI)) rdata <= reload_r[i][15:8];
            if (timer_hit(addr, i, `TIU_SUB_RLD_LO)) rdata <= reload_r[i][7:0];
            if (timer_hit(addr, i, `TIU_SUB_CNT_HI)) rdata <= count[i][15:8];
            if (timer_hit(addr, i, `TIU_SUB_CNT_LO)) rdata <= count[i][7:0];
          end
        end
      endcase
    end else begin
      rdata <= `TIU_RST_BYTE;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence uf_seq(int i);
    underflow[i] && !wr_stb;
  endsequence

  timer_flag_a: assert property (@(posedge clk) disable iff (rst)
    uf_seq(0) |=> flags_b_r[`TIU_B_TIMER0])
    else $error("timer underflow did not set flag");

  irq_hold_a: assert property (@(posedge clk) disable iff (rst)
    (flags_a_r[6:0] & en_a_r[6:0]) != 7'h00 |=> irq)
    else $error("request not raised for enabled flag");

  global_a: assert property (@(posedge clk) disable iff (rst)
    (flags_a_r[6:0] & en_a_r[6:0]) != 7'h00 |=> flags_b_r[`TIU_B_GLOBAL])
    else $error("global flag missing");

  tx_flag_a: assert property (@(posedge clk) disable iff (rst)
    tx_data_to_eof |=> flags_a_r[`TIU_A_TX])
    else $error("transmit done not flagged");

  rx_flag_a: assert property (@(posedge clk) disable iff (rst)
    rx_end |=> flags_a_r[`TIU_A_RX])
    else $error("receive done not flagged");

  err_flag_a: assert property (@(posedge clk) disable iff (rst)
    rx_error != 8'h00 |=> flags_a_r[`TIU_A_ERR])
    else $error("error not flagged");

  start_run_a: assert property (@(posedge clk) disable iff (rst)
    start[1] |=> running[1] ##0 count[1] == $past(reload_r[1]))
    else $error("timer did not start from reload");

  wake_a: assert property (@(posedge clk) disable iff (rst)
    standby && wake_uf |=> pw_r == tiu_pkg::tiu_pw_check)
    else $error("wake timer did not wake");

endmodule

//--- verification/tb_tiu_top.sv
// testbench of the timer and interrupt unit
// assumes: tiu_host drives the register port, bench drives events
`timescale 1ns/1ns

module tb_tiu_top;
  logic       clk;
  logic       rst;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic [3:0] ev;
  logic [9:0] lvl;
  logic [7:0] rx_err;
  logic [3:0] tse;
  logic       irq;
  logic       stby;
  logic       low_frequency_oscillator;
  logic       card;
  int         err_count;
  int         n_tests;

  tiu_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata));
  tiu_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .tx_data_to_eof(ev[0]), .rx_end(ev[1]), .cmd_to_idle(ev[2]),
    .fifo_level(lvl), .rx_error(rx_err), .rx_sof_seen(ev[3]),
    .card_detect(card), .lfo_tick(low_frequency_oscillator), .timer_stop_event(tse),
    .irq(irq), .standby(stby));

  // clock and reset
  always #2 clk = ~clk;
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ev = 4'h0;
    lvl = 10'h100;
    rx_err = 8'h00;
    tse = 4'h0;
    low_frequency_oscillator = 1'b0;
    card = 1'b0;
    err_count = 0;
    n_tests = 0;
  end

  // *************************************************
  // checks and drivers
  // *************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input logic [3:0] m, input logic [3:0] s);
    @(posedge clk);
    ev <= m;
    tse <= s;
    @(posedge clk);
    ev <= 4'h0;
    tse <= 4'h0;
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // *************************************************
  // scenarios
  // *************************************************
  task automatic t_regs();
    rchk(6'h06, 8'h08);
    rchk(6'h3f, 8'h00);
    host.wr(6'h00, 8'h85);
    rchk(6'h00, 8'h05);
    host.wr(6'h00, 8'h01);
    rchk(6'h00, 8'h04);
    host.wr(6'h00, 8'h7f);
  endtask
  task automatic t_events();
    pulse(4'hf, 4'h0);
    rx_err <= 8'h10;
    rchk(6'h00, 8'h27);
    rchk(6'h01, 8'h10);
    rx_err <= 8'h00;
    lvl <= 10'h1f8;
    rchk(6'h00, 8'h2f);
    lvl <= 10'h008;
    rchk(6'h00, 8'h3f);
    lvl <= 10'h100;
    host.wr(6'h00, 8'h7f);
    host.wr(6'h01, 8'h7f);
  endtask
  task automatic t_irq();
    host.wr(6'h02, 8'h81);
    pulse(4'h1, 4'h0);
    rchk(6'h04, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rchk(6'h01, 8'h40);
    host.wr(6'h00, 8'h01);
    rchk(6'h04, 8'h00);
    chk({7'h00, irq}, 8'h00);
    host.wr(6'h01, 8'h7f);
    host.wr(6'h02, 8'h7f);
  endtask
  task automatic t_timers();
    host.wr(6'h10, 8'h00);
    host.wr(6'h12, 8'h02);
    host.wr(6'h20, 8'h04);
    host.wr(6'h22, 8'h02);
    host.wr(6'h05, 8'h55);
    rchk(6'h05, 8'h05);
    repeat (100) @(posedge clk);
    rchk(6'h05, 8'h04);
    rchk(6'h14, 8'h00);
    rchk(6'h01, 8'h05);
    host.wr(6'h05, 8'h40);
    rchk(6'h05, 8'h00);
    host.wr(6'h01, 8'h05);
    rchk(6'h01, 8'h00);
    host.wr(6'h18, 8'h10);
    host.wr(6'h19, 8'h01);
    host.wr(6'h05, 8'h22);
    pulse(4'h0, 4'h2);
    rchk(6'h05, 8'h00);
    rchk(6'h01, 8'h00);
  endtask
  task automatic t_wake();
    host.wr(6'h07, 8'h03);
    host.wr(6'h04, 8'h02);
    @(posedge clk);
    chk({7'h00, stby}, 8'h01);
    low_frequency_oscillator <= 1'b1;
    repeat (6) @(posedge clk);
    low_frequency_oscillator <= 1'b0;
    chk({7'h00, stby}, 8'h00);
    card <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(6'h00, 8'h40);
    rchk(6'h04, 8'h00);
    card <= 1'b0;
    host.wr(6'h00, 8'h40);
    host.wr(6'h07, 8'h00);
  endtask
  task automatic t_reset();
    host.wr(6'h02, 8'h85);
    rchk(6'h02, 8'h05);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(6'h02, 8'h00);
    rchk(6'h06, 8'h08);
  endtask

  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_irq();
    t_timers();
    t_wake();
    t_reset();
    end_sim();
  end
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule

//--- verification/tiu_host.sv
// host model: register master on the plain port
// assumes: shares clk with the unit; drives right after rising edges
`timescale 1ns/1ns

module tiu_host (
  input  wire logic       clk,
  output logic [5:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata
);
  // idle bus at time zero
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // one-cycle read; data taken at the edge closing the following cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule
